// *** inc/rf_tx_regs.vh ***
// Register map and constants for the RF transmit mode sequencer.
// Assumes a byte-wide register port with one-cycle strobes.
// Summary of operation
// - Power-up bit starts RF logic; RF clock enable resets to one.
// - Crystal ready flag rises once crystal is stable; software waits for it.
// - Auto-cal bit starts VCO calibration and clears itself when done.
// - Five-bit VCO curve readable, writable; override bit forces written curve.
// - Direct select zero means Burst; modulation select zero OOK, one FSK.
// - Strobe in Burst sends FIFO bytes on RF output with chosen modulation.
// - Hardware clears transmit strobe when the burst finishes.
// - Strobing again resends previous FIFO data without reload.
// - Clearing strobe aborts burst, amplifier turned off; software waits 1 us.
// - Direct select one means Direct mode; symbol from direct data bit.
// - Synth enable turns on synthesizer in Direct mode; software waits before amplifier enable.
// - Amplifier enable in Direct mode emits current direct data bit.
// - Burst-complete interrupt has its own flag and enable in third MF register.
// - FIFO-margin interrupt flag rises when bytes left reach the margin.
// - Margin codes 0..3 select 4, 8, 16, 32 bytes; separate detect enable.
`ifndef RF_TX_REGS_VH
`define RF_TX_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define REG_CLK_CTRL 4'h0
`define REG_OPMOD 4'h1
`define REG_VCO2 4'h2
`define REG_TX_LEN 4'h3
`define REG_DATA_RATE 4'h4
`define REG_FREQ_DEVIATION_LO 4'h5
`define REG_FREQ_DEVIATION_HI 4'h6
`define REG_FIFO_DATA 4'h7
`define REG_FIFO_CTRL 4'h8
`define REG_MFI_THREE 4'h9
`define REG_STATUS 4'hA

// ****************************************
// Field positions
// ****************************************
`define CLK_XSEL_LSB 0
`define CLK_XHALVE 3
`define CLK_RHALVE 4
`define CLK_RF_EN 5
`define CLK_PWR_UP 6
`define OP_CAL 0
`define OP_DIRECT 1
`define OP_FSK 2
`define OP_STROBE 3
`define OP_SYNTH 4
`define OP_AMP 5
`define OP_DTX 6
`define VCO_OVR 7
`define FC_PTR_CLR 3
`define FC_MG_EN 2
`define MF_BD_EN 0
`define MF_MG_EN 1
`define MF_BD_FLAG 4
`define MF_MG_FLAG 5

// ****************************************
// Reset values and timing
// ****************************************
`define CLK_CTRL_RST 8'h20
`define DATA_RATE_RST 8'h0F
`define CAL_CYCLES_RST 16'h0200
`define XTAL_CYCLES_RST 16'h0100
`define CLK_PERIOD_NS 10
`define PA_OFF_NS 1000
// Amplifier-off wait: PA_OFF_NS at CLK_PERIOD_NS, sized for the 16-bit counter
`define PA_OFF_CYCLES 16'h0064

`endif

// *** design/tx_symbol_shifter.v ***
// Serialises one byte per load, MSB first, one bit per rate tick.
// Assumes the owner holds load for one cycle and gives the rate divider.
`timescale 1ns/100ps
module tx_symbol_shifter #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire reset,
    input wire load,
    input wire stop,
    input wire [W-1:0] byte_in,
    input wire [7:0] rate,
    output reg bit_out,
    output wire need_byte
);
    reg [W-1:0] sh_q;
    reg [3:0] cnt_q;
    reg [7:0] div_q;
    reg busy_q;

    assign need_byte = busy_q && cnt_q == 4'h0 && div_q == 8'h00;

    always @(posedge clk_sys) begin
        if (reset || stop) begin
            sh_q <= {W{1'b0}};
            cnt_q <= 4'h0;
            div_q <= 8'h00;
            busy_q <= 1'b0;
            bit_out <= 1'b0;
        end else if (load) begin
            sh_q <= byte_in << 1;
            bit_out <= byte_in[W-1];
            cnt_q <= W[3:0] - 4'h1;
            div_q <= rate;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            if (div_q != 8'h00) begin
                div_q <= div_q - 8'h01;
            end else if (cnt_q != 4'h0) begin
                bit_out <= sh_q[W-1];
                sh_q <= sh_q << 1;
                cnt_q <= cnt_q - 4'h1;
                div_q <= rate;
            end else begin
                // Byte exhausted; owner loads next or ends
                busy_q <= 1'b0;
                bit_out <= 1'b0;
            end
        end
    end
endmodule // tx_symbol_shifter

// *** design/rf_tx_mode_sequencer.v ***
// RF transmit mode sequencer: power, calibration, burst and direct modes.
// Assumes synchronous register strobes and a fixed XTAL_CYCLES crystal start-up count.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "rf_tx_regs.vh"
module rf_tx_mode_sequencer #(
    parameter DEPTH = 64,
    parameter AW = 6,
    parameter CAL_CYCLES = 512,
    parameter XTAL_CYCLES = 256
) (
    input wire clk_sys,
    input wire reset,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    input wire [4:0] cal_curve_in,
    output reg rf_output_pin,
    output reg modulation_fsk,
    output reg synth_on,
    output reg amp_on,
    output reg [4:0] vco_curve_select,
    output reg cal_active,
    output reg rf_clock_enable,
    output reg rf_power_up,
    output reg [2:0] crystal_select,
    output reg crystal_halve,
    output reg rf_clock_halve,
    output reg crystal_ready_flag,
    output reg [10:0] freq_deviation,
    output reg [7:0] data_rate,
    output wire irq_request
);
    // ****************************************
    // Burst states
    // ****************************************
    localparam S_IDLE = 2'h0;
    localparam S_SEND = 2'h1;
    localparam S_PA_OFF = 2'h2;

    function [5:0] margin_bytes;
        input [1:0] code;
        begin
            margin_bytes = 6'h04 << code;
        end
    endfunction

    reg [7:0] fifo_q [0:DEPTH-1];
    reg [AW-1:0] wptr_q;
    reg [7:0] rptr_q;
    reg [7:0] tx_length_bytes;
    reg auto_cal_start, direct_mode, strobe_q, synth_enable, amp_enable, direct_data_bit;
    reg curve_override;
    reg [4:0] curve_wr_q;
    reg [4:0] cal_result_q;
    reg fifo_margin_detect_enable;
    reg [1:0] fifo_margin_select;
    reg burst_done_irq_enable, fifo_margin_irq_enable;
    reg burst_done_flag, fifo_margin_flag;
    reg [1:0] state_q;
    reg [15:0] cal_cnt_q, xtal_cnt_q, off_cnt_q;
    reg load_q;
    integer i;

    wire bit_serial;
    wire need_byte;
    wire [7:0] clk_rst = `CLK_CTRL_RST;
    wire wr_op = wr_en && addr == `REG_OPMOD;
    wire sw_abort = wr_op && strobe_q && !wdata[`OP_STROBE];
    wire sw_start = wr_op && !strobe_q && wdata[`OP_STROBE] && !direct_mode
        && !wdata[`OP_DIRECT];
    wire last_byte = rptr_q >= tx_length_bytes;
    // burst end
    // Zero length ends at once, since the shifter never asks for a byte
    wire hw_done = state_q == S_SEND && last_byte && (need_byte || tx_length_bytes == 8'h00);
    wire [7:0] left = tx_length_bytes - rptr_q;
    wire margin_hit = state_q == S_SEND && load_q && fifo_margin_detect_enable
        && left == {2'b00, margin_bytes(fifo_margin_select)};

    assign irq_request = (burst_done_flag && burst_done_irq_enable)
        || (fifo_margin_flag && fifo_margin_irq_enable);

    tx_symbol_shifter #(.W(8)) u_shift (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(load_q),
        .stop(state_q != S_SEND),
        // Pointer has already moved past the byte being loaded
        .byte_in(fifo_q[rptr_q[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}]),
        .rate(data_rate),
        .bit_out(bit_serial),
        .need_byte(need_byte)
    );

    // ****************************************
    // Register writes and sequencing
    // ****************************************
    always @(posedge clk_sys) begin
        if (reset) begin
            {rf_power_up, rf_clock_enable, rf_clock_halve, crystal_halve, crystal_select} <=
                clk_rst[6:0];
            data_rate <= `DATA_RATE_RST;
            tx_length_bytes <= 8'h00;
            freq_deviation <= 11'h000;
            auto_cal_start <= 1'b0;
            direct_mode <= 1'b0;
            modulation_fsk <= 1'b0;
            strobe_q <= 1'b0;
            synth_enable <= 1'b0;
            amp_enable <= 1'b0;
            direct_data_bit <= 1'b0;
            curve_override <= 1'b0;
            curve_wr_q <= 5'h00;
            cal_result_q <= 5'h00;
            fifo_margin_detect_enable <= 1'b0;
            fifo_margin_select <= 2'b00;
            burst_done_irq_enable <= 1'b0;
            fifo_margin_irq_enable <= 1'b0;
            burst_done_flag <= 1'b0;
            fifo_margin_flag <= 1'b0;
            wptr_q <= {AW{1'b0}};
            rptr_q <= 8'h00;
            state_q <= S_IDLE;
            cal_cnt_q <= 16'h0000;
            xtal_cnt_q <= 16'h0000;
            off_cnt_q <= 16'h0000;
            load_q <= 1'b0;
            crystal_ready_flag <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                fifo_q[i] <= 8'h00;
            end
        end else begin
            load_q <= 1'b0;
            if (wr_en) begin
                case (addr)
                    `REG_CLK_CTRL: begin
                        crystal_select <= wdata[2:0];
                        crystal_halve <= wdata[`CLK_XHALVE];
                        rf_clock_halve <= wdata[`CLK_RHALVE];
                        rf_clock_enable <= wdata[`CLK_RF_EN];
                        rf_power_up <= wdata[`CLK_PWR_UP];
                    end
                    `REG_OPMOD: begin
                        if (wdata[`OP_CAL] && !auto_cal_start) begin
                            auto_cal_start <= 1'b1;
                            cal_cnt_q <= CAL_CYCLES[15:0];
                        end
                        direct_mode <= wdata[`OP_DIRECT];
                        modulation_fsk <= wdata[`OP_FSK];
                        synth_enable <= wdata[`OP_SYNTH];
                        amp_enable <= wdata[`OP_AMP];
                        direct_data_bit <= wdata[`OP_DTX];
                    end
                    `REG_VCO2: begin
                        curve_wr_q <= wdata[4:0];
                        curve_override <= wdata[`VCO_OVR];
                    end
                    `REG_TX_LEN: tx_length_bytes <= wdata;
                    `REG_DATA_RATE: data_rate <= wdata;
                    `REG_FREQ_DEVIATION_LO: freq_deviation[7:0] <= wdata;
                    `REG_FREQ_DEVIATION_HI: freq_deviation[10:8] <= wdata[2:0];
                    `REG_FIFO_DATA: begin
                        fifo_q[wptr_q] <= wdata;
                        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
                    end
                    `REG_FIFO_CTRL: begin
                        fifo_margin_select <= wdata[1:0];
                        fifo_margin_detect_enable <= wdata[`FC_MG_EN];
                        if (wdata[`FC_PTR_CLR]) begin
                            wptr_q <= {AW{1'b0}};
                        end
                    end
                    `REG_MFI_THREE: begin
                        burst_done_irq_enable <= wdata[`MF_BD_EN];
                        fifo_margin_irq_enable <= wdata[`MF_MG_EN];
                    end
                    default: begin
                    end
                endcase
            end
            // Flag clears by writing zero; a same-cycle set still wins
            if (wr_en && addr == `REG_MFI_THREE) begin
                burst_done_flag <= wdata[`MF_BD_FLAG] || hw_done;
                fifo_margin_flag <= wdata[`MF_MG_FLAG] || margin_hit;
            end else begin
                if (hw_done) begin
                    burst_done_flag <= 1'b1;
                end
                if (margin_hit) begin
                    fifo_margin_flag <= 1'b1;
                end
            end

            if (auto_cal_start) begin
                if (cal_cnt_q <= 16'h0001) begin
                    auto_cal_start <= 1'b0;
                    cal_result_q <= cal_curve_in;
                end else begin
                    cal_cnt_q <= cal_cnt_q - 16'h0001;
                end
            end

            if (!rf_power_up || !rf_clock_enable) begin
                xtal_cnt_q <= XTAL_CYCLES[15:0];
                crystal_ready_flag <= 1'b0;
            end else if (xtal_cnt_q != 16'h0000) begin
                xtal_cnt_q <= xtal_cnt_q - 16'h0001;
            end else begin
                crystal_ready_flag <= 1'b1;
            end

            case (state_q)
                S_IDLE: begin
                    if (sw_start) begin
                        strobe_q <= 1'b1;
                        rptr_q <= 8'h00;
                        state_q <= S_SEND;
                    end
                end
                S_SEND: begin
                    if (sw_abort) begin
                        strobe_q <= 1'b0;
                        off_cnt_q <= `PA_OFF_CYCLES;
                        state_q <= S_PA_OFF;
                    end else if (hw_done) begin
                        strobe_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (rptr_q == 8'h00 && !load_q && need_byte == 1'b0) begin
                        load_q <= 1'b1;
                        rptr_q <= 8'h01;
                    end else if (need_byte) begin
                        load_q <= 1'b1;
                        rptr_q <= rptr_q + 8'h01;
                    end
                end
                S_PA_OFF: begin
                    if (off_cnt_q <= 16'h0001) begin
                        state_q <= S_IDLE;
                    end else begin
                        off_cnt_q <= off_cnt_q - 16'h0001;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ****************************************
    // RF outputs and read port
    // ****************************************
    always @(posedge clk_sys) begin
        if (reset) begin
            rf_output_pin <= 1'b0;
            synth_on <= 1'b0;
            amp_on <= 1'b0;
            vco_curve_select <= 5'h00;
            cal_active <= 1'b0;
            rdata <= 8'h00;
        end else begin
            cal_active <= auto_cal_start;
            vco_curve_select <= curve_override ? curve_wr_q : cal_result_q;
            if (direct_mode) begin
                synth_on <= synth_enable && rf_power_up;
                amp_on <= amp_enable && synth_enable && rf_power_up;
                rf_output_pin <= amp_enable && direct_data_bit;
            end else begin
                synth_on <= state_q == S_SEND && rf_power_up;
                amp_on <= state_q == S_SEND && rf_power_up;
                rf_output_pin <= state_q == S_SEND && bit_serial;
            end
            rdata <= 8'h00;
            if (rd_en) begin
                case (addr)
                    `REG_CLK_CTRL: rdata <= {1'b0, rf_power_up, rf_clock_enable,
                        rf_clock_halve, crystal_halve, crystal_select};
                    `REG_OPMOD: rdata <= {1'b0, direct_data_bit, amp_enable, synth_enable,
                        strobe_q, modulation_fsk, direct_mode, auto_cal_start};
                    `REG_VCO2: rdata <= {curve_override, 2'b00,
                        curve_override ? curve_wr_q : cal_result_q};
                    `REG_TX_LEN: rdata <= tx_length_bytes;
                    `REG_DATA_RATE: rdata <= data_rate;
                    `REG_FREQ_DEVIATION_LO: rdata <= freq_deviation[7:0];
                    `REG_FREQ_DEVIATION_HI: rdata <= {5'h00, freq_deviation[10:8]};
                    `REG_FIFO_CTRL: rdata <= {5'h00, fifo_margin_detect_enable,
                        fifo_margin_select};
                    `REG_MFI_THREE: rdata <= {2'b00, fifo_margin_flag, burst_done_flag,
                        2'b00, fifo_margin_irq_enable, burst_done_irq_enable};
                    `REG_STATUS: rdata <= {6'h00, state_q == S_PA_OFF, crystal_ready_flag};
                    default: rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // rf_tx_mode_sequencer

// *** verif/rf_tx_checker.sv ***
// Port-level assertions for the RF transmit mode sequencer.
// Assumes one clock domain; bound into every sequencer instance.
`timescale 1ns/100ps
module rf_tx_checker #(
    parameter CAL_CYCLES = 512,
    parameter XTAL_CYCLES = 256
) (
    input logic clk_sys,
    input logic reset,
    input logic [3:0] addr,
    input logic [7:0] wdata,
    input logic wr_en,
    input logic rd_en,
    input logic [7:0] rdata,
    input logic [4:0] cal_curve_in,
    input logic rf_output_pin,
    input logic amp_on,
    input logic [4:0] vco_curve_select,
    input logic cal_active,
    input logic rf_clock_enable,
    input logic rf_power_up,
    input logic crystal_ready_flag,
    input logic [10:0] freq_deviation,
    input logic [7:0] data_rate
);
    // Slack covers the output register stages
    localparam int CLIM = CAL_CYCLES + 8;
    localparam int XLIM = XTAL_CYCLES + 8;
    logic dir_q;
    logic dtx_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ****************
    // Mode bits as software last wrote them
    // ****************
    always @(posedge clk_sys) begin
        if (reset) begin
            dir_q <= 1'b0;
            dtx_q <= 1'b0;
        end else if (wr_en && addr == 4'h1) begin
            dir_q <= wdata[1];
            dtx_q <= wdata[6];
        end
    end
    sequence direct_steady;
        (amp_on && dir_q && !wr_en) [*3];
    endsequence
    property clk_write_p;
        logic [7:0] d;
        (wr_en && addr == 4'h0, d = wdata) |=> rf_power_up == d[6] && rf_clock_enable == d[5];
    endproperty
    // ****************
    // Assertions
    // ****************
    a_read_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_reset_levels: assert property (
        $fell(reset) |-> rf_clock_enable && !rf_power_up && data_rate == 8'h0F)
        else $error("reset levels wrong");
    a_clock_write: assert property (clk_write_p)
        else $error("power or clock enable not updated");
    a_freq_deviation_low: assert property (
        wr_en && addr == 4'h5 |=> freq_deviation[7:0] == $past(wdata))
        else $error("deviation low byte not updated");
    a_crystal_ready: assert property (
        $rose(rf_power_up) |-> ##[1:XLIM] crystal_ready_flag)
        else $error("crystal ready late");
    a_cal_ends: assert property ($rose(cal_active) |-> ##[1:CLIM] !cal_active)
        else $error("calibration did not end");
    a_cal_capture: assert property (
        $fell(cal_active) |-> ##[0:1] vco_curve_select == cal_curve_in)
        else $error("curve not captured");
    a_direct_pin: assert property (direct_steady |-> rf_output_pin == dtx_q)
        else $error("direct bit not on output");
    a_burst_amp: assert property (
        wr_en && addr == 4'h1 && wdata[3] && !wdata[1] && !amp_on |-> ##[1:4] amp_on)
        else $error("amplifier not on for burst");
    a_abort_amp: assert property (
        wr_en && addr == 4'h1 && !wdata[3] && !wdata[1] && amp_on |-> ##[1:102] !amp_on)
        else $error("amplifier still on after abort");
endmodule // rf_tx_checker

bind rf_tx_mode_sequencer rf_tx_checker #(
    .CAL_CYCLES(CAL_CYCLES),
    .XTAL_CYCLES(XTAL_CYCLES)
) u_chk (
    .clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cal_curve_in(cal_curve_in),
    .rf_output_pin(rf_output_pin), .amp_on(amp_on), .vco_curve_select(vco_curve_select),
    .cal_active(cal_active), .rf_clock_enable(rf_clock_enable), .rf_power_up(rf_power_up),
    .crystal_ready_flag(crystal_ready_flag), .freq_deviation(freq_deviation),
    .data_rate(data_rate)
);

// *** verif/testbench.sv ***
// Self-checking bench for the RF transmit mode sequencer.
// Assumes the register index map of the sequencer header.
`timescale 1ns/100ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [4:0] cal_curve_in = 5'h00;
    wire [7:0] rdata;
    wire [4:0] vco_curve_select;
    wire [10:0] freq_deviation;
    wire rf_output_pin, modulation_fsk, synth_on, amp_on, rf_clock_enable, rf_power_up;
    wire crystal_ready_flag, irq_request;
    wire [2:0] xsel;
    wire xh, rh, cal_act;
    wire [7:0] drate;
    logic [31:0] rs = 32'h0000AF07;
    logic [7:0] exp_rd[$];
    logic exp_bit[$];
    logic [7:0] fifo[$];
    logic rd_q = 1'b0;
    int bcnt = 0;
    int miscompares = 0;
    int checked = 0;
    // Short counts keep calibration and crystal start quick
    rf_tx_mode_sequencer #(.CAL_CYCLES(8), .XTAL_CYCLES(4)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .cal_curve_in(cal_curve_in),
        .rf_output_pin(rf_output_pin), .modulation_fsk(modulation_fsk), .synth_on(synth_on),
        .amp_on(amp_on), .vco_curve_select(vco_curve_select), .cal_active(cal_act),
        .rf_clock_enable(rf_clock_enable), .rf_power_up(rf_power_up), .crystal_select(xsel),
        .crystal_halve(xh), .rf_clock_halve(rh), .crystal_ready_flag(crystal_ready_flag),
        .freq_deviation(freq_deviation), .data_rate(drate), .irq_request(irq_request)
    );
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // ****************
    // Bus and compare tasks
    // ****************
    task automatic rnd(output logic [7:0] r);
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        r = rs[7:0];
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Strobes stay up until idle lowers them, so every wait goes through idle
    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        addr <= a;
        rd_en <= 1'b1;
        wr_en <= 1'b0;
        @(posedge clk_sys);
        exp_rd.push_back(e);
    endtask
    task automatic poll(input logic [3:0] a, input int b, input logic v);
        int n;
        n = 0;
        while (n < 3000) begin
            addr <= a;
            rd_en <= 1'b1;
            wr_en <= 1'b0;
            @(posedge clk_sys);
            idle(1);
            n = (rdata[b] === v) ? 9999 : n + 1;
        end
        chk1(n == 9999, 1'b1);
    endtask
    task automatic load(input int n, input logic [7:0] fc);
        logic [7:0] b;
        fifo.delete();
        wr(4'h8, fc | 8'h08);
        repeat (n) begin
            rnd(b);
            fifo.push_back(b);
            wr(4'h7, b);
        end
        wr(4'h3, n[7:0]);
    endtask
    task automatic expect_bits;
        foreach (fifo[i]) for (int k = 7; k >= 0; k--) exp_bit.push_back(fifo[i][k]);
    endtask
    task automatic done(input string s);
        $display("test %s finished at %0t", s, $time);
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****************
    // Monitor: read data and burst bits sampled mid-bit (16 cycles each)
    // ****************
    always @(posedge clk_sys) begin
        rd_q <= rd_en;
        if (rd_q && exp_rd.size() > 0) chk8(rdata, exp_rd.pop_front());
        if (wr_en && addr == 4'h1 && wdata[3] && exp_bit.size() > 0) bcnt <= 1;
        else if (bcnt > 0 && exp_bit.size() > 0) bcnt <= bcnt + 1;
        else bcnt <= 0;
        if (bcnt % 16 == 11 && exp_bit.size() > 0) chk1(rf_output_pin, exp_bit.pop_front());
    end
    initial begin
        #500000;
        miscompares++;
        tally_and_finish();
    end
    // ****************
    // Tests
    // ****************
    initial begin
        logic [7:0] v;
        logic [7:0] w;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rnd(v);
        cal_curve_in <= v[4:0];
        rd(4'h0, 8'h20);
        rd(4'h4, 8'h0F);
        rd(4'h9, 8'h00);
        rd(4'hA, 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(4'h0, 8'h7D);
        rd(4'h0, 8'h7D);
        idle(1);
        poll(4'hA, 0, 1'b1);
        chk1(crystal_ready_flag, 1'b1);
        chk8({3'h0, rh, xh, xsel}, 8'h1D);
        chk8(drate, 8'h0F);
        done("power");
        wr(4'h1, 8'h01);
        idle(2);
        chk1(cal_act, 1'b1);
        poll(4'h1, 0, 1'b0);
        rd(4'h2, {3'h0, v[4:0]});
        rnd(w);
        wr(4'h2, {3'h4, w[4:0]});
        rd(4'h2, {3'h4, w[4:0]});
        idle(2);
        chk8({3'h0, vco_curve_select}, {3'h0, w[4:0]});
        done("calibration");
        wr(4'h5, w);
        wr(4'h6, 8'h05);
        load(2, 8'h00);
        wr(4'h9, 8'h01);
        expect_bits();
        wr(4'h1, 8'h08);
        idle(2);
        chk1(modulation_fsk, 1'b0);
        poll(4'h1, 3, 1'b0);
        chk1(exp_bit.size() == 0, 1'b1);
        chk1(irq_request, 1'b1);
        rd(4'h9, 8'h11);
        chk8({5'h00, freq_deviation[10:8]}, 8'h05);
        chk8(freq_deviation[7:0], w);
        wr(4'h9, 8'h01);
        rd(4'h9, 8'h01);
        expect_bits();
        wr(4'h1, 8'h0C);
        idle(2);
        chk1(modulation_fsk, 1'b1);
        chk1(irq_request, 1'b0);
        poll(4'h1, 3, 1'b0);
        chk1(exp_bit.size() == 0, 1'b1);
        done("burst");
        wr(4'h9, 8'h02);
        for (int c = 0; c < 4; c++) begin
            load((4 << c) + 2, {6'h01, c[1:0]});
            wr(4'h1, 8'h08);
            idle(1);
            poll(4'h1, 3, 1'b0);
            chk1(irq_request, 1'b1);
            rd(4'h9, 8'h32);
            wr(4'h9, 8'h02);
        end
        done("margin");
        wr(4'h9, 8'h01);
        load(6, 8'h00);
        wr(4'h1, 8'h08);
        idle(40);
        chk1(amp_on, 1'b1);
        wr(4'h1, 8'h00);
        idle(2);
        rd(4'h1, 8'h00);
        rd(4'hA, 8'h03);
        rd(4'h9, 8'h01);
        idle(110);
        chk1(amp_on, 1'b0);
        chk1(irq_request, 1'b0);
        rd(4'hA, 8'h01);
        done("abort");
        wr(4'h5, 8'h33);
        wr(4'h1, 8'h42);
        wr(4'h1, 8'h52);
        idle(4);
        chk1(synth_on, 1'b1);
        chk1(amp_on, 1'b0);
        wr(4'h1, 8'h72);
        idle(4);
        chk1(rf_output_pin, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rnd(w);
            wr(4'h1, {1'b0, w[0], 6'h32});
            idle(4);
            chk1(rf_output_pin, w[0]);
        end
        wr(4'h1, 8'h3A);
        rd(4'h1, 8'h32);
        wr(4'h1, 8'h12);
        idle(100);
        wr(4'h1, 8'h02);
        wr(4'h0, 8'h5D);
        wr(4'h0, 8'h1D);
        idle(3);
        chk1(synth_on | amp_on | rf_clock_enable | rf_power_up, 1'b0);
        done("direct");
        idle(4);
        tally_and_finish();
    end
endmodule // testbench
